// File: pot_i2c_pkg.sv
// Constants and types for the dual pot I2C slave front end.
// Assumes a 10 MHz core clock; SCL and SDA arrive asynchronously.
// How it works
// - Nonvolatile write commits EEPROM on STOP
// - Volatile write accepts STOP, no programming
// - START is SDA falling while SCL high
// - STOP is SDA rising while SCL high
// - Repeated START handled as ordinary START
// - Incoming bits sampled on SCL rising edge
// - Outgoing bits driven at SCL falling edge
// - Ninth bit is acknowledge, low means ACK
// - Bytes are eight bits, MSB first
// - Master NACKs last read; device releases SDA
// - Address is 0101 plus three pins
// - Wrong address ignored until next START
// - Many command bytes per write accepted
// - No address ACK during EEPROM programming
// - Every commit programs all three bytes
// - Zero-crossing delays start of programming
// - Read direction sends data; first wiper 0
// - Read order wiper0, wiper1, config, wrap
// - Command top bits select wiper0/wiper1/config/none
// - Config bits: volatile, zero-cross, positions
// - Enable pin high ignores the bus
`default_nettype none
package pot_i2c_pkg;
  localparam logic [3:0] ADDR_FIXED       = 4'h5;
  localparam logic [1:0] SEL_WIPER0       = 2'h0;
  localparam logic [1:0] SEL_WIPER1       = 2'h1;
  localparam logic [1:0] SEL_CONFIG       = 2'h2;
  localparam int         CFG_VOLATILE_BIT = 2;
  localparam int         CFG_ZERO_BIT     = 1;
  localparam int         CFG_POS_BIT      = 0;
  localparam logic [7:0] CONFIG_RESET     = 8'h87;
  localparam logic [7:0] WIPER_RESET      = 8'h00;
  localparam int         CLOCK_HZ         = 10_000_000;
  localparam int         PROG_TIME_US     = 10;
  localparam int         PROG_CYCLES      = PROG_TIME_US * (CLOCK_HZ / 1_000_000);
  typedef struct packed {
    logic [7:0] wiper0;
    logic [7:0] wiper1;
    logic [7:0] config_byte;
  } store_type;
endpackage
`default_nettype wire

// File: pot_prog_timer.sv
// EEPROM programming sequencer: waits for zero-cross, then counts the program time.
// Assumes start pulse and zero-cross done level on the core clock.
`default_nettype none
module pot_prog_timer (
  input  wire logic I_CLOCK,
  input  wire logic I_RST_N,
  input  wire logic i_start,
  input  wire logic i_zero_en,
  input  wire logic i_zero_done,
  output var  logic o_busy,
  output var  logic o_program
);
  typedef enum logic [1:0] {IDLE, WAIT_ZERO, PROG} prog_state_type;
  prog_state_type state_reg, state_next;
  logic [15:0] count_reg, count_next;
  logic        prog_reg, prog_next;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    prog_next  = 1'b0;
    unique case (state_reg)
      IDLE: begin
        if (i_start) begin
          state_next = i_zero_en ? WAIT_ZERO : PROG;
          count_next = 16'h0000;
        end
      end
      WAIT_ZERO: begin
        if (i_zero_done) begin
          state_next = PROG;
        end
      end
      PROG: begin
        prog_next  = 1'b1;
        count_next = count_reg + 16'h0001;
        if (count_reg == 16'(pot_i2c_pkg::PROG_CYCLES - 1)) begin
          state_next = IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= IDLE;
      count_reg <= 16'h0000;
      prog_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      prog_reg  <= prog_next;
    end
  end

  assign o_busy    = (state_reg != IDLE);
  assign o_program = prog_reg;

  a_zero_waits: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == WAIT_ZERO && !i_zero_done) |=> !prog_reg)
    else $error("Programming began before zero-cross done");
  a_prog_length: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    $rose(prog_reg) |-> prog_reg [*8])
    else $error("Programming window too short");
endmodule
`default_nettype wire

// File: pot_i2c_slave.sv
// I2C slave front end of a dual digital potentiometer.
// Assumes SCL, SDA, enable and address pins are asynchronous to I_CLOCK.
`default_nettype none
module pot_i2c_slave (
  input  wire logic       I_CLOCK,
  input  wire logic       I_RST_N,
  input  wire logic       I_SCL,
  input  wire logic       I_SDA,
  input  wire logic       I_CE_N,
  input  wire logic       I_ADDR_PIN_0,
  input  wire logic       I_ADDR_PIN_1,
  input  wire logic       I_ADDR_PIN_2,
  input  wire logic       I_ZERO_DONE,
  output var  logic       O_SDA,
  output var  logic       O_SDA_OE,
  output var  logic [7:0] O_WIPER0,
  output var  logic [7:0] O_WIPER1,
  output var  logic [7:0] O_CONFIG,
  output var  logic       O_PROGRAM,
  output var  logic       O_BUSY,
  output var  logic [23:0] O_PROG_DATA
);
  typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, WR_BYTE, WR_ACK, RD_BYTE, RD_ACK} st_type;

  // Two-flop synchronisers
  logic [5:0] sync1_reg, sync1_next;
  logic [5:0] sync2_reg, sync2_next;
  logic       scl_d_reg, scl_d_next;
  logic       sda_d_reg, sda_d_next;
  logic       scl_s, sda_s, ce_n_s;
  logic [2:0] pins_s;

  always_comb begin
    sync1_next = {I_SCL, I_SDA, I_CE_N, I_ADDR_PIN_2, I_ADDR_PIN_1, I_ADDR_PIN_0};
    sync2_next = sync1_reg;
    scl_d_next = scl_s;
    sda_d_next = sda_s;
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sync1_reg <= 6'h3F;
      sync2_reg <= 6'h3F;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      scl_d_reg <= scl_d_next;
      sda_d_reg <= sda_d_next;
    end
  end

  assign scl_s  = sync2_reg[5];
  assign sda_s  = sync2_reg[4];
  assign ce_n_s = sync2_reg[3];
  assign pins_s = sync2_reg[2:0];

  logic start_det, stop_det, scl_rise, scl_fall;
  assign start_det = !ce_n_s && scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det  = !ce_n_s && scl_s && scl_d_reg && !sda_d_reg && sda_s;
  assign scl_rise  = !ce_n_s && scl_s && !scl_d_reg;
  assign scl_fall  = !ce_n_s && !scl_s && scl_d_reg;

  // Main protocol state
  st_type                 state_reg, state_next;
  logic [7:0]             shift_reg, shift_next;
  logic [3:0]             bit_reg, bit_next;
  logic                   sda_oe_reg, sda_oe_next;
  logic [1:0]             rd_idx_reg, rd_idx_next;
  logic                   wrote_reg, wrote_next;
  logic                   ack_ok_reg, ack_ok_next;
  pot_i2c_pkg::store_type live_reg, live_next;
  pot_i2c_pkg::store_type prog_data_reg, prog_data_next;
  logic                   start_prog;
  logic                   busy, prog_run;

  function automatic logic [7:0] read_sel(input pot_i2c_pkg::store_type s, input logic [1:0] i);
    read_sel = (i == 2'h0) ? s.wiper0 : (i == 2'h1) ? s.wiper1 : s.config_byte;
  endfunction

  always_comb begin
    state_next     = state_reg;
    shift_next     = shift_reg;
    bit_next       = bit_reg;
    sda_oe_next    = sda_oe_reg;
    rd_idx_next    = rd_idx_reg;
    wrote_next     = wrote_reg;
    ack_ok_next    = ack_ok_reg;
    live_next      = live_reg;
    prog_data_next = prog_data_reg;
    start_prog     = 1'b0;
    if (ce_n_s) begin
      state_next  = IDLE;
      sda_oe_next = 1'b0;
    end else if (start_det) begin
      state_next  = ADDR;
      bit_next    = 4'h0;
      sda_oe_next = 1'b0;
      wrote_next  = 1'b0;
    end else if (stop_det) begin
      state_next  = IDLE;
      sda_oe_next = 1'b0;
      if (wrote_reg && !live_reg.config_byte[pot_i2c_pkg::CFG_VOLATILE_BIT]) begin
        start_prog     = 1'b1;
        prog_data_next = live_reg;
      end
      wrote_next = 1'b0;
    end else begin
      unique case (state_reg)
        IDLE: begin
          sda_oe_next = 1'b0;
        end
        ADDR, WR_BYTE: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s};
            bit_next   = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == 4'h8) begin
            bit_next = 4'h0;
            if (state_reg == ADDR) begin
              ack_ok_next = !busy && shift_reg[7:1] == {pot_i2c_pkg::ADDR_FIXED, pins_s};
              state_next  = ADDR_ACK;
              sda_oe_next = !busy && shift_reg[7:1] == {pot_i2c_pkg::ADDR_FIXED, pins_s};
            end else begin
              state_next  = WR_ACK;
              sda_oe_next = 1'b1;
              wrote_next  = 1'b1;
              unique case (shift_reg[7:6])
                pot_i2c_pkg::SEL_WIPER0: live_next.wiper0 = {2'h0, shift_reg[5:0]};
                pot_i2c_pkg::SEL_WIPER1: live_next.wiper1 = {2'h0, shift_reg[5:0]};
                pot_i2c_pkg::SEL_CONFIG: live_next.config_byte = {5'h10, shift_reg[2:0]};
                default: wrote_next = wrote_reg;
              endcase
            end
          end
        end
        ADDR_ACK: begin
          if (scl_fall) begin
            if (!ack_ok_reg) begin
              state_next  = IDLE;
              sda_oe_next = 1'b0;
            end else if (shift_reg[0]) begin
              state_next  = RD_BYTE;
              rd_idx_next = 2'h1;
              shift_next  = read_sel(live_reg, 2'h0);
              sda_oe_next = !live_reg.wiper0[7];
            end else begin
              state_next  = WR_BYTE;
              sda_oe_next = 1'b0;
            end
          end
        end
        WR_ACK: begin
          if (scl_fall) begin
            state_next  = WR_BYTE;
            sda_oe_next = 1'b0;
          end
        end
        RD_BYTE: begin
          if (scl_fall) begin
            bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'h7) begin
              state_next  = RD_ACK;
              sda_oe_next = 1'b0;
            end else begin
              shift_next  = {shift_reg[6:0], 1'b0};
              sda_oe_next = !shift_reg[6];
            end
          end
        end
        RD_ACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state_next = IDLE;
            end else begin
              shift_next  = read_sel(live_reg, rd_idx_reg);
              rd_idx_next = (rd_idx_reg == 2'h2) ? 2'h0 : rd_idx_reg + 2'h1;
              bit_next    = 4'h0;
            end
          end else if (scl_fall) begin
            state_next  = RD_BYTE;
            sda_oe_next = !shift_reg[7];
          end
        end
        default: state_next = IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg     <= IDLE;
      shift_reg     <= 8'h00;
      bit_reg       <= 4'h0;
      sda_oe_reg    <= 1'b0;
      rd_idx_reg    <= 2'h0;
      wrote_reg     <= 1'b0;
      ack_ok_reg    <= 1'b0;
      live_reg      <= '{pot_i2c_pkg::WIPER_RESET, pot_i2c_pkg::WIPER_RESET,
                         pot_i2c_pkg::CONFIG_RESET};
      prog_data_reg <= '{pot_i2c_pkg::WIPER_RESET, pot_i2c_pkg::WIPER_RESET,
                         pot_i2c_pkg::CONFIG_RESET};
    end else begin
      state_reg     <= state_next;
      shift_reg     <= shift_next;
      bit_reg       <= bit_next;
      sda_oe_reg    <= sda_oe_next;
      rd_idx_reg    <= rd_idx_next;
      wrote_reg     <= wrote_next;
      ack_ok_reg    <= ack_ok_next;
      live_reg      <= live_next;
      prog_data_reg <= prog_data_next;
    end
  end

  // Zero-cross done is a pin as well
  logic zero1_reg,      zero1_next;
  logic sync2_zero_reg, sync2_zero_next;
  logic busy_reg,       busy_next;

  always_comb begin
    zero1_next      = I_ZERO_DONE;
    sync2_zero_next = zero1_reg;
    busy_next       = busy;
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      zero1_reg      <= 1'b0;
      sync2_zero_reg <= 1'b0;
      busy_reg       <= 1'b0;
    end else begin
      zero1_reg      <= zero1_next;
      sync2_zero_reg <= sync2_zero_next;
      busy_reg       <= busy_next;
    end
  end

  pot_prog_timer u_prog (
    .I_CLOCK     (I_CLOCK),
    .I_RST_N     (I_RST_N),
    .i_start     (start_prog),
    .i_zero_en   (live_reg.config_byte[pot_i2c_pkg::CFG_ZERO_BIT]),
    .i_zero_done (sync2_zero_reg),
    .o_busy      (busy),
    .o_program   (prog_run)
  );

  // Open drain: only ever drives low
  assign O_SDA       = 1'b0;
  assign O_SDA_OE    = sda_oe_reg;
  assign O_WIPER0    = live_reg.wiper0;
  assign O_WIPER1    = live_reg.wiper1;
  assign O_CONFIG    = live_reg.config_byte;
  assign O_PROGRAM   = prog_run;
  assign O_BUSY      = busy_reg;
  assign O_PROG_DATA = prog_data_reg;

  // Framing and link checks
  a_ce_blocks: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    ce_n_s |=> !sda_oe_reg && state_reg == IDLE)
    else $error("Bus active while enable pin high");
  a_start_addr: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    start_det |=> state_reg == ADDR && bit_reg == 4'h0)
    else $error("START not recognised");
  a_stop_idle: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    stop_det |=> state_reg == IDLE && !sda_oe_reg)
    else $error("STOP not recognised");
  a_bit_sample: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    ((state_reg == ADDR || state_reg == WR_BYTE) && scl_rise)
    |=> shift_reg[0] == $past(sda_s))
    else $error("Bit not sampled on SCL rise");
  a_idle_quiet: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == IDLE && !start_det) |=> !sda_oe_reg)
    else $error("SDA driven while not addressed");
  a_addr_ack_drive: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == ADDR && scl_fall && bit_reg == 4'h8 && !busy
     && shift_reg[7:1] == {pot_i2c_pkg::ADDR_FIXED, pins_s})
    |=> sda_oe_reg && state_reg == ADDR_ACK)
    else $error("Matching address not acknowledged");
  a_busy_nack: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == ADDR_ACK && busy) |-> !ack_ok_reg || !$past(busy, 2))
    else $error("Address acknowledged while busy");
  a_wr_ack: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == WR_BYTE && scl_fall && bit_reg == 4'h8 && !stop_det && !start_det && !ce_n_s)
    |=> sda_oe_reg && state_reg == WR_ACK)
    else $error("Command byte not acknowledged");
  a_ack_release: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == WR_ACK && scl_fall) |=> !sda_oe_reg && state_reg == WR_BYTE)
    else $error("SDA held after acknowledge");
  a_rd_release: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == RD_BYTE && scl_fall && bit_reg == 4'h7)
    |=> !sda_oe_reg && state_reg == RD_ACK)
    else $error("SDA not released for master acknowledge");
  a_nack_release: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == RD_ACK && scl_rise && sda_s) |=> !sda_oe_reg [*2])
    else $error("SDA held after master NACK");
  a_rd_first: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == ADDR_ACK && scl_fall && ack_ok_reg && shift_reg[0] && !ce_n_s)
    |=> shift_reg == live_reg.wiper0)
    else $error("First read byte not wiper 0");
  a_rd_second: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == RD_ACK && scl_rise && !sda_s && rd_idx_reg == 2'h1)
    |=> shift_reg == live_reg.wiper1)
    else $error("Second read byte not wiper 1");
  a_rd_third: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == RD_ACK && scl_rise && !sda_s && rd_idx_reg == 2'h2)
    |=> shift_reg == live_reg.config_byte && rd_idx_reg == 2'h0)
    else $error("Third read byte not config or no wrap");

  // Command decode and commit checks
  a_vol_noprog: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    start_prog |-> !live_reg.config_byte[pot_i2c_pkg::CFG_VOLATILE_BIT])
    else $error("Programming in volatile mode");
  a_nv_commit: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    start_prog |=> prog_data_reg == $past(live_reg) ##1 busy_reg)
    else $error("Commit did not capture all bytes");
  a_wiper0_set: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == WR_BYTE && scl_fall && bit_reg == 4'h8
     && shift_reg[7:6] == pot_i2c_pkg::SEL_WIPER0)
    |=> live_reg.wiper0 == {2'h0, $past(shift_reg[5:0])})
    else $error("Wiper 0 command not applied");
  a_wiper1_set: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == WR_BYTE && scl_fall && bit_reg == 4'h8
     && shift_reg[7:6] == pot_i2c_pkg::SEL_WIPER1)
    |=> live_reg.wiper1 == {2'h0, $past(shift_reg[5:0])})
    else $error("Wiper 1 command not applied");
  a_cfg_set: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == WR_BYTE && scl_fall && bit_reg == 4'h8
     && shift_reg[7:6] == pot_i2c_pkg::SEL_CONFIG)
    |=> live_reg.config_byte == {5'h10, $past(shift_reg[2:0])})
    else $error("Config command not applied");
  a_reserved_noop: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (state_reg == WR_BYTE && scl_fall && bit_reg == 4'h8
     && shift_reg[7:6] == 2'h3)
    |=> $stable(live_reg))
    else $error("Reserved command changed state");

  // Scenario covers
  c_write: cover property (@(posedge I_CLOCK) state_reg == WR_ACK);
  c_read_wrap: cover property (@(posedge I_CLOCK) state_reg == RD_ACK && rd_idx_reg == 2'h0);
  c_commit: cover property (@(posedge I_CLOCK) start_prog);
  c_poll_refused: cover property (@(posedge I_CLOCK) state_reg == ADDR_ACK && busy && !ack_ok_reg);
  c_nack_end: cover property (@(posedge I_CLOCK) state_reg == RD_ACK && scl_rise && sda_s);
endmodule
`default_nettype wire

// File: i2c_master_model.sv
// I2C bus master model: drives SCL and pulls SDA low on a pulled-up line.
// Assumes the bench resolves SDA from all enables and feeds it back here.
`default_nettype none
module i2c_master_model (
  input  wire logic clk,
  input  wire logic sda_in,
  output var  logic scl,
  output var  logic sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end
  // Quarter of an 800 ns bus period, ending just after a core clock edge
  task automatic q();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // SDA moves only while SCL is low
  task automatic bit_io(input logic b, output logic r);
    q();
    sda_oe = ~b;
    q();
    scl = 1'b1;
    q();
    r = sda_in;
    q();
    scl = 1'b0;
  endtask
  task automatic start();
    if (scl == 1'b0) begin
      q();
      q();
      sda_oe = 1'b0;
      q();
      scl = 1'b1;
      q();
    end
    sda_oe = 1'b1;
    q();
    scl = 1'b0;
  endtask
  task automatic stop();
    q();
    sda_oe = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_oe = 1'b0;
    q();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Last byte is refused so the slave lets go of SDA
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// File: dual_pot_i2c_slave_access_tb.sv
// Testbench for the dual pot I2C slave front end.
// Assumes pot_i2c_pkg, the design and i2c_master_model are compiled first.
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module dual_pot_i2c_slave_access_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_n, scl, m_oe, ce_n, zero_done, ack;
  logic        s_out, s_oe, program_o, busy;
  logic [2:0]  apin;
  logic [7:0]  w0, w1, cfg, rd;
  logic [23:0] pdata;
  int          n_errors, num_checks, cycles, n;
  wire         sda = ~(m_oe | (s_oe & ~s_out));
  i2c_master_model u_master (.clk(clk), .sda_in(sda), .scl(scl), .sda_oe(m_oe));
  pot_i2c_slave u_dut (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA(sda), .I_CE_N(ce_n),
    .I_ADDR_PIN_0(apin[0]), .I_ADDR_PIN_1(apin[1]), .I_ADDR_PIN_2(apin[2]),
    .I_ZERO_DONE(zero_done), .O_SDA(s_out), .O_SDA_OE(s_oe), .O_WIPER0(w0),
    .O_WIPER1(w1), .O_CONFIG(cfg), .O_PROGRAM(program_o), .O_BUSY(busy),
    .O_PROG_DATA(pdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic end_sim();
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      end_sim();
    end
  end
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] b, input logic exp_ack);
    u_master.wbyte(b, ack);
    `CHK(ack, exp_ack)
  endtask
  task automatic rd_chk(input logic last, input logic [7:0] exp_d);
    u_master.rbyte(last, rd);
    `CHK(rd, exp_d)
  endtask
  initial begin
    rst_n = 1'b0;
    ce_n = 1'b0;
    apin = 3'h5;
    zero_done = 1'b0;
    idle(2);
    rst_n = 1'b1;
    idle(4);
    `CHK({w0, w1, cfg, busy, program_o}, {8'h00, 8'h00, 8'h87, 2'h0})
    // Volatile write of several commands, reserved one included
    u_master.start();
    wr(8'h5A, 1'b1);
    wr(8'h15, 1'b1);
    wr(8'h6A, 1'b1);
    wr(8'hC3, 1'b1);
    u_master.stop();
    idle(6);
    `CHK({w0, w1, cfg, busy}, {8'h15, 8'h2A, 8'h87, 1'b0})
    // Round-robin read with wrap, last byte refused
    u_master.start();
    wr(8'h5B, 1'b1);
    rd_chk(1'b0, 8'h15);
    rd_chk(1'b0, 8'h2A);
    rd_chk(1'b0, 8'h87);
    rd_chk(1'b1, 8'h15);
    u_master.stop();
    // Every pin setting: wrong address ignored, repeated START recovers
    for (int a = 0; a < 8; a++) begin
      apin = a[2:0];
      u_master.start();
      wr({4'h5, ~a[2:0], 1'b0}, 1'b0);
      u_master.start();
      wr({4'h5, a[2:0], 1'b0}, 1'b1);
      u_master.stop();
    end
    apin = 3'h5;
    // Bus ignored while disabled
    ce_n = 1'b1;
    u_master.start();
    wr(8'h5A, 1'b0);
    u_master.stop();
    ce_n = 1'b0;
    // Nonvolatile commit held back by zero-cross, address polling refused
    u_master.start();
    wr(8'h5A, 1'b1);
    wr(8'h82, 1'b1);
    u_master.stop();
    idle(4);
    `CHK({cfg, busy, program_o}, {8'h82, 2'h2})
    u_master.start();
    wr(8'h5A, 1'b0);
    u_master.stop();
    `CHK(program_o, 1'b0)
    zero_done = 1'b1;
    n = 0;
    while (program_o !== 1'b1 && n < 20) begin
      idle(1);
      n++;
    end
    `CHK(pdata, {8'h15, 8'h2A, 8'h82})
    n = 0;
    while (program_o === 1'b1 && n < 200) begin
      idle(1);
      n++;
    end
    `CHK(n, pot_i2c_pkg::PROG_CYCLES)
    idle(2);
    `CHK(busy, 1'b0)
    // Write then repeated START into a single-byte read
    u_master.start();
    wr(8'h5A, 1'b1);
    wr(8'h05, 1'b1);
    u_master.start();
    wr(8'h5B, 1'b1);
    rd_chk(1'b1, 8'h05);
    u_master.stop();
    idle(4);
    `CHK(busy, 1'b0)
    end_sim();
  end
endmodule
`default_nettype wire
